/* src/rx_video_pass_qualifier.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "rx_video_pass_qualifier_map.svh"

module rx_video_pass_qualifier #(
   parameter int LEN_W = 16,
   parameter int LINES_W = 16,
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rx_video_pass_qualifier_pkg::video_beat_type vid_in,
   input wire logic link_lock,
   input wire logic link_parity_err,
   input wire logic csi_parity_err,
   input wire logic tx_synced,
   input wire logic rx_port_irq,
   output rx_video_pass_qualifier_pkg::video_beat_type vid_out,
   output logic pass,
   output logic cutoff_err,
   output logic irq
);
   import rx_video_pass_qualifier_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.

   logic [`QC_WIDTH-1:0] qual_ctrl_r;
   logic [`CUT_WIDTH-1:0] cut_cfg_r;
   logic [`IRQ_WIDTH-1:0] irq_enable_r;
   logic [`IRQ_WIDTH-1:0] irq_status_r;
   logic [`IRQ_WIDTH-1:0] irq_clear_r;
   logic [31:0] prdata_r;
   logic pass_r;
   logic synced_r;
   logic irq_pass_q;
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic [LEN_W-1:0] byte_cnt_r;
   logic [LEN_W-1:0] ref_len_r;
   logic len_known_r;
   logic [LINES_W-1:0] line_cnt_r;
   logic [LINES_W-1:0] ref_lines_r;
   logic lines_known_r;
   logic frame_bad_r;
   logic cutoff_r;
   logic len_chg_r;
   logic lines_chg_r;
   logic stat_clear_r;
   frame_state_type state_r;
   frame_state_type state_nxt;
   video_beat_type vid_out_r;

   // Decoded bus access.
   logic setup_phase;
   logic access_done;
   logic [7:0] idx;
   logic mapped;

   // Qualification terms.
   logic [1:0] thresh;
   logic chk_len;
   logic chk_lines;
   logic chk_par;
   logic len_err;
   logic lines_err;
   logic par_err;
   logic restart;
   logic frame_ok;
   logic cut_now;
   logic fwd_now;
   logic [`IRQ_WIDTH-1:0] irq_events;

   // Bitwise edge detection used for both pass and sync changes.
   function automatic logic rose(input logic now_v, input logic was_v);
      rose = now_v & ~was_v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB slave decode.

   // The word index is taken from the byte address; misaligned is unmapped.
   assign idx = paddr[9:2];
   assign mapped = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0) &&
                   (idx == `IRQ_ENABLE_IDX || idx == `IRQ_STATUS_IDX || idx == `QUAL_CTRL_IDX ||
                    idx == `CUTOFF_CFG_IDX || idx == `PORT_STATUS_IDX);
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable;
   assign pready = access_done;
   assign pslverr = access_done & ~mapped;
   assign prdata = prdata_r;

   // Read data is captured in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
         irq_clear_r <= '0;
         stat_clear_r <= 1'b0;
      end else if (setup_phase) begin
         prdata_r <= 32'h0000_0000;
         irq_clear_r <= '0;
         stat_clear_r <= 1'b0;
         if (!pwrite && mapped) begin
            unique case (idx)
               `IRQ_ENABLE_IDX: prdata_r[`IRQ_WIDTH-1:0] <= irq_enable_r;
               `IRQ_STATUS_IDX: begin
                  prdata_r[`IRQ_WIDTH-1:0] <= irq_status_r;
                  irq_clear_r <= irq_status_r;
               end
               `QUAL_CTRL_IDX: prdata_r[`QC_WIDTH-1:0] <= qual_ctrl_r;
               `CUTOFF_CFG_IDX: prdata_r[`CUT_WIDTH-1:0] <= cut_cfg_r;
               `PORT_STATUS_IDX: begin
                  prdata_r[`ST_PASS] <= pass_r;
                  prdata_r[`ST_COUNT_MSB:`ST_COUNT_LSB] <= count_r;
                  prdata_r[`ST_CUTOFF] <= cutoff_r;
                  prdata_r[`ST_LINE_SIZE_CHG] <= len_chg_r;
                  prdata_r[`ST_LINE_TOTAL_CHG] <= lines_chg_r;
                  stat_clear_r <= 1'b1;
               end
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software-written controls take effect at the completing access edge.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         qual_ctrl_r <= `QC_RESET;
         cut_cfg_r <= `CUT_RESET;
         irq_enable_r <= `IRQ_ENABLE_RESET;
      end else if (access_done && pwrite) begin
         if (idx == `QUAL_CTRL_IDX && mapped) begin
            qual_ctrl_r <= pwdata[`QC_WIDTH-1:0];
         end
         if (idx == `CUTOFF_CFG_IDX && mapped) begin
            cut_cfg_r <= pwdata[`CUT_WIDTH-1:0];
         end
         if (idx == `IRQ_ENABLE_IDX && mapped) begin
            irq_enable_r <= pwdata[`IRQ_WIDTH-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line size and line count measurement.

   assign thresh = qual_ctrl_r[`QC_THRESH_MSB:`QC_THRESH_LSB];
   assign chk_len = qual_ctrl_r[`QC_CHK_LINE_SIZE];
   assign chk_lines = qual_ctrl_r[`QC_CHK_LINE_TOTAL];
   assign chk_par = qual_ctrl_r[`QC_CHK_PARITY];

   // A line that ends short or runs past the reference is a size change.
   assign len_err = len_known_r && ((vid_in.le && byte_cnt_r != ref_len_r) ||
                    (vid_in.dv && byte_cnt_r == ref_len_r));
   // A frame that ends short or starts a line beyond the reference count.
   assign lines_err = lines_known_r && ((vid_in.fe && line_cnt_r != ref_lines_r) ||
                      (vid_in.ls && line_cnt_r == ref_lines_r));
   assign par_err = chk_par & link_parity_err;

   // Bytes of the current line, and the reference length across frames.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         byte_cnt_r <= '0;
         ref_len_r <= '0;
         len_known_r <= 1'b0;
      end else if (!link_lock) begin
         byte_cnt_r <= '0;
         len_known_r <= 1'b0;
      end else if (vid_in.ls) begin
         byte_cnt_r <= '0;
      end else if (vid_in.le) begin
         ref_len_r <= byte_cnt_r;
         len_known_r <= 1'b1;
      end else if (vid_in.dv) begin
         byte_cnt_r <= byte_cnt_r + 1'b1;
      end
   end

   // Lines of the current frame, and the reference count across frames.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         line_cnt_r <= '0;
         ref_lines_r <= '0;
         lines_known_r <= 1'b0;
      end else if (!link_lock) begin
         line_cnt_r <= '0;
         lines_known_r <= 1'b0;
      end else if (vid_in.fs) begin
         line_cnt_r <= '0;
      end else if (vid_in.fe) begin
         ref_lines_r <= line_cnt_r;
         lines_known_r <= 1'b1;
      end else if (vid_in.le) begin
         line_cnt_r <= line_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Valid frame counter and Pass.

   // Any enabled size change or parity error restarts qualification.
   assign restart = (chk_len & len_err) | (chk_lines & lines_err) | par_err;
   // A parity error does not spoil its own frame, so pass comes one frame early.
   assign frame_ok = vid_in.fe && !restart && !frame_bad_r;

   // Frames disqualified by a size change stay bad until their end.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_bad_r <= 1'b0;
      end else if (vid_in.fs) begin
         frame_bad_r <= 1'b0;
      end else if ((chk_len & len_err) | (chk_lines & lines_err)) begin
         frame_bad_r <= 1'b1;
      end
   end

   // Next count: cleared on loss of lock or restart, saturating at threshold.
   always_comb begin
      count_nxt = count_r;
      if (!link_lock || restart) begin
         count_nxt = 2'b00;
      end else if (frame_ok && count_r < thresh) begin
         count_nxt = count_r + 2'b01;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= 2'b00;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Pass needs lock and a full count; a zero threshold follows lock and the enabled parity check alone.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pass_r <= 1'b0;
      end else begin
         pass_r <= link_lock && !par_err && (count_nxt >= thresh);
      end
   end

   assign pass = pass_r;

   ////////////////////////////////////////////////////////////////////////////
   // Forwarding, discard and cutoff.

   assign cut_now = (cut_cfg_r[`CUT_LINE_SIZE] & len_err) | (cut_cfg_r[`CUT_LINE_TOTAL] & lines_err) |
                    (cut_cfg_r[`CUT_CSI_PARITY] & csi_parity_err);

   // A frame start always opens a new frame, which resumes output after a cut unless discard is on and pass is low.
   always_comb begin
      state_nxt = state_r;
      fwd_now = 1'b0;
      if (vid_in.fs) begin
         if (qual_ctrl_r[`QC_DISCARD_EN] && !pass_r) begin
            state_nxt = ST_DROP;
         end else begin
            state_nxt = ST_FORWARD;
            fwd_now = 1'b1;
         end
      end else begin
         unique case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_FORWARD: begin
               if (cut_now) begin
                  state_nxt = ST_CUT;
               end else begin
                  fwd_now = 1'b1;
                  if (vid_in.fe) begin
                     state_nxt = ST_IDLE;
                  end
               end
            end
            ST_CUT, ST_DROP: begin
               if (vid_in.fe) begin
                  state_nxt = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Beats reach the buffers only while the frame is forwarded.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         vid_out_r <= '0;
      end else begin
         vid_out_r <= fwd_now ? vid_in : '0;
      end
   end

   assign vid_out = vid_out_r;

   // Sticky error flags; a new event wins over a clear by status read.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cutoff_r <= 1'b0;
         len_chg_r <= 1'b0;
         lines_chg_r <= 1'b0;
      end else begin
         cutoff_r <= (state_r == ST_FORWARD && !vid_in.fs && cut_now) ||
                     (cutoff_r && !(access_done && stat_clear_r));
         len_chg_r <= len_err || (len_chg_r && !(access_done && stat_clear_r));
         lines_chg_r <= lines_err || (lines_chg_r && !(access_done && stat_clear_r));
      end
   end

   assign cutoff_err = cutoff_r;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit port interrupt status and enable.

   always_comb begin
      irq_events = '0;
      irq_events[`IRQ_PASS] = rose(pass_r, irq_pass_q);
      irq_events[`IRQ_SYNCED] = rose(tx_synced, synced_r);
      irq_events[`IRQ_PASS_LOST] = rose(irq_pass_q, pass_r);
      irq_events[`IRQ_SYNC_LOST] = rose(synced_r, tx_synced);
      irq_events[`IRQ_RX_PORT] = rx_port_irq;
   end

   // Previous pass and sync levels feed the edge events above.

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_pass_q <= 1'b0;
         synced_r <= 1'b0;
      end else begin
         irq_pass_q <= pass_r;
         synced_r <= tx_synced;
      end
   end

   // Status sets on every event whatever the enable; reading clears what was read.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_r <= '0;
      end else begin
         irq_status_r <= irq_events | (irq_status_r & ~(access_done ? irq_clear_r : '0));
      end
   end

   // The enable only gates the interrupt line.
   assign irq = |(irq_status_r & irq_enable_r);

endmodule

/* src/rx_video_pass_qualifier_map.svh */
`ifndef RX_VIDEO_PASS_QUALIFIER_MAP_SVH
`define RX_VIDEO_PASS_QUALIFIER_MAP_SVH

// Register indices; the byte address of a register is four times its index.
`define IRQ_ENABLE_IDX 8'h36
`define IRQ_STATUS_IDX 8'h37
`define QUAL_CTRL_IDX 8'h38
`define CUTOFF_CFG_IDX 8'h39
`define PORT_STATUS_IDX 8'h3A

// Fields of qualification_control.
`define QC_THRESH_LSB 0
`define QC_THRESH_MSB 1
`define QC_CHK_LINE_SIZE 2
`define QC_CHK_LINE_TOTAL 3
`define QC_CHK_PARITY 4
`define QC_DISCARD_EN 5
`define QC_WIDTH 6
`define QC_RESET 6'h00

// Fields of port_cutoff_config; by default every cutoff is on.
`define CUT_LINE_SIZE 0
`define CUT_LINE_TOTAL 1
`define CUT_CSI_PARITY 2
`define CUT_WIDTH 3
`define CUT_RESET 3'h7

// Fields of the transmit port interrupt registers.
`define IRQ_PASS 0
`define IRQ_SYNCED 1
`define IRQ_PASS_LOST 2
`define IRQ_SYNC_LOST 3
`define IRQ_RX_PORT 4
`define IRQ_WIDTH 8
`define IRQ_ENABLE_RESET 8'h00

// Fields of the port status register.
`define ST_PASS 0
`define ST_COUNT_LSB 1
`define ST_COUNT_MSB 2
`define ST_CUTOFF 3
`define ST_LINE_SIZE_CHG 4
`define ST_LINE_TOTAL_CHG 5

`endif

/* src/rx_video_pass_qualifier_pkg.sv */
package rx_video_pass_qualifier_pkg;

   // One cycle of received or forwarded video: strobes and a data byte.
   typedef struct packed {
      logic fs;
      logic fe;
      logic ls;
      logic le;
      logic dv;
      logic [7:0] data;
   } video_beat_type;

   // Where the current frame stands on its way to the buffers.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FORWARD = 2'b01,
      ST_CUT = 2'b10,
      ST_DROP = 2'b11
   } frame_state_type;

endpackage

/* verification/rx_video_pass_qualifier_sva.sv */
`timescale 1ns/1ps
// Watches the qualifier's ports and shadows the control registers it needs.
module rx_video_pass_qualifier_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire rx_video_pass_qualifier_pkg::video_beat_type vid_in,
   input wire logic link_lock,
   input wire logic link_parity_err,
   input wire logic csi_parity_err,
   input wire logic tx_synced,
   input wire logic rx_port_irq,
   input wire rx_video_pass_qualifier_pkg::video_beat_type vid_out,
   input wire logic pass,
   input wire logic cutoff_err,
   input wire logic irq
);
   import rx_video_pass_qualifier_pkg::*;
   logic [5:0] qc_r;
   logic [2:0] cut_r;
   logic [7:0] en_r;
   logic in_frame_r;
   logic wr;
   logic acc;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   // Shadows the control registers as the bus writes them.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         qc_r <= 6'h00;
         cut_r <= 3'h7;
         en_r <= 8'h00;
      end else begin
         if (wr && paddr == 12'h0E0) qc_r <= pwdata[5:0];
         if (wr && paddr == 12'h0E4) cut_r <= pwdata[2:0];
         if (wr && paddr == 12'h0D8) en_r <= pwdata[7:0];
      end
   end
   // Tracks whether the source is between a frame start and its frame end.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) in_frame_r <= 1'h0;
      else if (vid_in.fs) in_frame_r <= 1'h1;
      else if (vid_in.fe) in_frame_r <= 1'h0;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   ready_access_a: assert property (acc |-> pready) else $error("pready missing in access phase");
   idle_quiet_a: assert property (!psel |-> !pready && !pslverr) else $error("bus answer while idle");
   unmapped_err_a: assert property (acc && !(paddr inside {12'h0D8, 12'h0DC, 12'h0E0, 12'h0E4, 12'h0E8})
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   fwd_copy_a: assert property (vid_out != '0 |-> vid_out == $past(vid_in)) else $error("output beat not a copy");
   zero_thresh_a: assert property ($rose(link_lock) && qc_r[1:0] == 2'h0 && !qc_r[4] |=> pass)
      else $error("pass did not follow lock");
   pass_lock_a: assert property ($rose(pass) |-> $past(link_lock)) else $error("pass rose without lock");
   parity_drop_a: assert property (qc_r[4] && link_parity_err |=> !pass) else $error("pass kept on parity error");
   discard_drop_a: assert property (qc_r[5] && !pass && vid_in.fs |=> !vid_out.fs)
      else $error("frame start forwarded before pass");
   parity_cut_a: assert property (cut_r[2] && csi_parity_err && in_frame_r && !acc && (!qc_r[5] || pass)
      |=> cutoff_err && vid_out == '0) else $error("frame not cut on camera parity error");
   irq_gate_a: assert property (en_r == 8'h00 |-> !irq) else $error("interrupt with all enables off");
   cover property ($rose(pass));
   cover property ($rose(cutoff_err));
   cover property ($rose(irq));
   cover property (vid_out.fe);
endmodule

bind rx_video_pass_qualifier rx_video_pass_qualifier_sva #(.ADDR_W(ADDR_W)) rx_video_pass_qualifier_sva_inst (
   .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vid_in(vid_in), .link_lock(link_lock),
   .link_parity_err(link_parity_err), .csi_parity_err(csi_parity_err), .tx_synced(tx_synced),
   .rx_port_irq(rx_port_irq), .vid_out(vid_out), .pass(pass), .cutoff_err(cutoff_err), .irq(irq));

/* verification/rx_video_pass_qualifier_test.sv */
`timescale 1ns/1ps
`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin $display("[ERR] %s exp %0h got %0h", nm, x, g); n_mismatch++; end end
// Drives the qualifier from the bus side and from a far-end video source.
module rx_video_pass_qualifier_test;
   import rx_video_pass_qualifier_pkg::*;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_type;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, link_lock, tx_synced, rx_port_irq;
   logic link_parity_err, csi_parity_err, pass, cutoff_err, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   video_beat_type vid_in, vid_out;
   int n_mismatch, n_checks, cyc, n_fs, n_fe, fs0, fe0;
   row_type rows [15] = '{'{0, 12'h0E0, 0, 32'h0, 0}, '{0, 12'h0E4, 0, 32'h7, 0}, '{0, 12'h0D8, 0, 32'h0, 0},
      '{0, 12'h0DC, 0, 32'h0, 0}, '{0, 12'h0E8, 0, 32'h0, 0}, '{1, 12'h0D8, 32'hFFFF_FFFF, 0, 0},
      '{0, 12'h0D8, 0, 32'hFF, 0}, '{1, 12'h0DC, 32'hFF, 0, 0}, '{0, 12'h0DC, 0, 32'h0, 0},
      '{1, 12'h0E4, 32'h2, 0, 0}, '{0, 12'h0E4, 0, 32'h2, 0}, '{1, 12'h0E4, 32'h7, 0, 0},
      '{0, 12'h100, 0, 32'h0, 1}, '{1, 12'h0D9, 0, 0, 1}, '{1, 12'h0D8, 0, 0, 0}};
   rx_video_pass_qualifier rx_video_pass_qualifier_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vid_in(vid_in), .link_lock(link_lock), .link_parity_err(link_parity_err),
      .csi_parity_err(csi_parity_err), .tx_synced(tx_synced), .rx_port_irq(rx_port_irq), .vid_out(vid_out),
      .pass(pass), .cutoff_err(cutoff_err), .irq(irq));
   video_source video_source_inst (.core_clk(core_clk), .vid(vid_in), .link_parity_err(link_parity_err),
      .csi_parity_err(csi_parity_err));
   ////////////////////////////////////////////////////////////////////////////////
   // Prints the verdict and ends the run.
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // One bus transfer: setup, then access held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frm(input int l, input int b, input int p);
      fs0 = n_fs;
      fe0 = n_fe;
      video_source_inst.send_frame(l, b, p);
   endtask
   task automatic relock();
      @(posedge core_clk);
      link_lock <= 1'b0;
      tick(2);
      link_lock <= 1'b1;
      tick(2);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Counts forwarded frame starts and ends, and cuts a hang short.
   always @(posedge core_clk) begin
      n_fs += (vid_out.fs === 1'b1);
      n_fe += (vid_out.fe === 1'b1);
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   // Main sequence: register rows, then interrupt, qualification, cutoff and discard cases.
   initial begin
      {reset_n, psel, penable, pwrite, link_lock, tx_synced, rx_port_irq} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      tick(5);
      reset_n <= 1'b1;
      tick(1);
      `CHK("reset outputs", 4'h0, {pass, cutoff_err, irq, |vid_out});
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) `CHK("rdata", rows[i].q, rd);
         `CHK("pslverr", rows[i].e, er);
      end
      link_lock <= 1'b1;
      tick(2);
      `CHK("pass", 1'b1, pass);
      tx_synced <= 1'b1;
      rx_port_irq <= 1'b1;
      tick(1);
      rx_port_irq <= 1'b0;
      link_lock <= 1'b0;
      tx_synced <= 1'b0;
      tick(3);
      `CHK("irq", 1'b0, irq);
      apb(1, 12'h0D8, 32'h4);
      tick(1);
      `CHK("irq", 1'b1, irq);
      apb(0, 12'h0DC, 0);
      `CHK("irq status", 32'h1F, rd);
      tick(1);
      `CHK("irq", 1'b0, irq);
      apb(1, 12'h0D8, 0);
      // Threshold two with line size, line total and parity checks on, discard off.
      apb(1, 12'h0E0, 32'h1E);
      relock();
      frm(3, 4, 0);
      `CHK("pass", 1'b0, pass);
      frm(3, 4, 0);
      `CHK("pass", 1'b1, pass);
      frm(3, 4, 0);
      apb(0, 12'h0E8, 0);
      `CHK("status", 32'h5, rd & 32'h7);
      frm(3, 5, 0);
      `CHK("frame ends", fe0, n_fe);
      `CHK("cutoff flag", 1'b1, cutoff_err);
      apb(0, 12'h0E8, 0);
      `CHK("status", 32'h18, rd & 32'h1E);
      relock();
      frm(3, 4, 1);
      `CHK("frame ends", fe0 + 1, n_fe);
      apb(0, 12'h0E8, 0);
      `CHK("status", 32'h2, rd & 32'h7);
      frm(3, 4, 0);
      `CHK("pass", 1'b1, pass);
      frm(2, 4, 0);
      `CHK("frame ends", fe0, n_fe);
      apb(0, 12'h0E8, 0);
      `CHK("status", 32'h20, rd & 32'h26);
      frm(2, 4, 2);
      `CHK("frame starts", fs0 + 1, n_fs);
      `CHK("frame ends", fe0, n_fe);
      apb(1, 12'h0E0, 32'h21);
      relock();
      frm(3, 4, 0);
      `CHK("frame starts", fs0, n_fs);
      `CHK("pass", 1'b1, pass);
      frm(3, 4, 0);
      `CHK("frame starts", fs0 + 1, n_fs);
      // Mid-run reset: outputs clear at once and the controls return to their reset values.
      reset_n <= 1'b0;
      tick(2);
      `CHK("reset outputs", 4'h0, {pass, cutoff_err, irq, |vid_out});
      reset_n <= 1'b1;
      apb(0, 12'h0E0, 0);
      `CHK("rdata", 32'h0, rd);
      apb(0, 12'h0E4, 0);
      `CHK("rdata", 32'h7, rd);
      finish_test();
   end
endmodule

/* verification/video_source.sv */
`timescale 1ns/1ps
// Far-end video source; it sends whole frames when the bench asks for them.
module video_source (
   input wire logic core_clk,
   output rx_video_pass_qualifier_pkg::video_beat_type vid,
   output logic link_parity_err,
   output logic csi_parity_err
);
   import rx_video_pass_qualifier_pkg::*;
   logic [7:0] seq_r;
   // Outputs start idle so that no strobe is seen before the first frame.
   initial begin
      vid = '0;
      seq_r = 8'h00;
      link_parity_err = 1'h0;
      csi_parity_err = 1'h0;
   end
   // Sends one beat per clock; the data byte is inverted on beats that carry no byte.
   task automatic beat(input logic [4:0] s, input logic pe, input logic ce);
      @(posedge core_clk);
      vid <= {s, s[0] ? seq_r : ~vid.data};
      seq_r <= seq_r + 8'h01;
      link_parity_err <= pe;
      csi_parity_err <= ce;
   endtask
   // Sends a frame with an optional error at its first line start (1 link parity, 2 camera parity).
   task automatic send_frame(input int lines, input int len, input int err);
      beat(5'h10, 1'h0, 1'h0);
      beat(5'h00, 1'h0, 1'h0);
      for (int l = 0; l < lines; l++) begin
         beat(5'h04, err == 1 && l == 0, err == 2 && l == 0);
         for (int b = 0; b < len; b++) begin
            beat(5'h01, 1'h0, 1'h0);
         end
         beat(5'h02, 1'h0, 1'h0);
      end
      beat(5'h08, 1'h0, 1'h0);
      repeat (3) beat(5'h00, 1'h0, 1'h0);
   endtask
endmodule
